// [rtl/pin4_mux_defines.svh]
// offsets, field positions, reset values and the function list of the pin 4 output mux
// Function
// - source field bits 4:2: rx ports 0-3, 100 device status, 101 reserved, 110/111 tx ports
// - rx port source, select 000-011 drives remote pin states 0-3 of that port
// - rx port source, select 100 lock, 101 pass, 110 frame valid, 111 line valid
// - device status source, select 000 drives the stored pin 0 drive value
// - device status, 001 OR of enabled lock, 010 AND of enabled pass
// - device status, select codes 011 and 101 to 111 are reserved
// - device status, select 100 drives the frame sync pulse
// - tx port source, 000 AND and 001 OR of selected rx port pass
// - tx port source, 010 frame valid, 011 line valid of that tx port
// - tx port source, 100 synchronized, 101 port interrupt, 110/111 reserved
// - bit 1 holds a software value driven when local value is chosen and LOCAL_IS_PIN0 is 0
// - driver enabled only while bit 0 is 1
// - control register at 0x14, read/write, resets to 0x00
`ifndef PIN4_MUX_DEFINES_SVH
`define PIN4_MUX_DEFINES_SVH

// ---------------------------------------------
// register map
// ---------------------------------------------
`define PIN4_CTL_ADDR 8'h14
`define RX_ENABLE_ADDR 8'h20
`define TX_RX_SEL_ADDR 8'h24
`define PIN4_STATUS_ADDR 8'h28

// ---------------------------------------------
// reset values
// ---------------------------------------------
`define PIN4_CTL_RESET 8'h00
`define RX_ENABLE_RESET 4'hf
`define TX_RX_SEL_RESET 8'hff

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define CTL_EN_BIT 0
`define CTL_VAL_BIT 1
`define CTL_SRC_LSB 2
`define CTL_SRC_MSB 4
`define CTL_SEL_LSB 5
`define CTL_SEL_MSB 7

// ---------------------------------------------
// per-source reserved select codes, one bit per code
// ---------------------------------------------
`define DEV_RSVD_MASK 8'he8
`define TX_RSVD_MASK 8'hc0

`endif

// [rtl/pin4_mux_pkg.sv]
// types shared by the pin 4 output mux
package pin4_mux_pkg;

  // ---------------------------------------------
  // output source codes
  // ---------------------------------------------
  typedef enum logic [2:0] {
    SRC_RX0 = 3'b000,
    SRC_RX1 = 3'b001,
    SRC_RX2 = 3'b010,
    SRC_RX3 = 3'b011,
    SRC_DEV = 3'b100,
    SRC_RSVD = 3'b101,
    SRC_TX0 = 3'b110,
    SRC_TX1 = 3'b111
  } source_t;

  // ---------------------------------------------
  // bus slave states
  // ---------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK = 2'b01,
    ST_DONE = 2'b10
  } bus_state_t;

endpackage : pin4_mux_pkg

// [rtl/pin_sel_if.sv]
// control and source bundle between the register block and the signal mux
`timescale 1ns/10ps
interface pin_sel_if;
  logic [2:0] source;
  logic [2:0] select;
  logic localVal;
  logic [15:0] rxRemote;
  logic [3:0] rxLock;
  logic [3:0] rxPass;
  logic [3:0] rxFv;
  logic [3:0] rxLv;
  logic [3:0] rxEnable;
  logic [7:0] txRxSel;
  logic [1:0] txFv;
  logic [1:0] txLv;
  logic [1:0] txSync;
  logic [1:0] txIrq;
  logic frameSyncIn;
  logic level;
  logic reservedCode;

  modport ctrl (
    output source, select, localVal, rxRemote, rxLock, rxPass, rxFv, rxLv,
    output rxEnable, txRxSel, txFv, txLv, txSync, txIrq, frameSyncIn,
    input level, reservedCode
  );
  modport mux (
    input source, select, localVal, rxRemote, rxLock, rxPass, rxFv, rxLv,
    input rxEnable, txRxSel, txFv, txLv, txSync, txIrq, frameSyncIn,
    output level, reservedCode
  );
endinterface : pin_sel_if

// [rtl/pin4_signal_mux.sv]
// combinational selection of the pin 4 drive level
`timescale 1ns/10ps
`include "pin4_mux_defines.svh"
module pin4_signal_mux (
  pin_sel_if.mux sel
);

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // empty mask counts as not passing, so no port means no pass
  function automatic logic allOf(input logic [3:0] val, input logic [3:0] mask);
    allOf = (mask != 4'h0) && ((val & mask) == mask);
  endfunction : allOf

  function automatic logic anyOf(input logic [3:0] val, input logic [3:0] mask);
    anyOf = (val & mask) != 4'h0;
  endfunction : anyOf

  // ---------------------------------------------
  // rx port source
  // ---------------------------------------------
  wire [1:0] rxIdx = sel.source[1:0];
  wire [3:0] rxPins = sel.rxRemote[{rxIdx, 2'b00} +: 4];
  wire [7:0] rxVec = {sel.rxLv[rxIdx], sel.rxFv[rxIdx], sel.rxPass[rxIdx],
                      sel.rxLock[rxIdx], rxPins};

  // ---------------------------------------------
  // device status source
  // ---------------------------------------------
  wire devLock = anyOf(sel.rxLock, sel.rxEnable);
  wire devPass = allOf(sel.rxPass, sel.rxEnable);
  wire [7:0] devVec = {3'h0, sel.frameSyncIn, 1'b0, devPass, devLock, sel.localVal};

  // ---------------------------------------------
  // tx port source
  // ---------------------------------------------
  wire txIdx = sel.source[0];
  wire [3:0] txMask = txIdx ? sel.txRxSel[7:4] : sel.txRxSel[3:0];
  wire [7:0] txVec = {2'h0, sel.txIrq[txIdx], sel.txSync[txIdx], sel.txLv[txIdx],
                      sel.txFv[txIdx], anyOf(sel.rxPass, txMask),
                      allOf(sel.rxPass, txMask)};

  // ---------------------------------------------
  // final pick
  // ---------------------------------------------
  wire isRx = ~sel.source[2];
  wire isDev = sel.source == pin4_mux_pkg::SRC_DEV;
  wire isTx = sel.source[2] & sel.source[1];
  wire [7:0] rsvdMask = isDev ? `DEV_RSVD_MASK : (isTx ? `TX_RSVD_MASK : 8'h00);

  assign sel.reservedCode = (sel.source == pin4_mux_pkg::SRC_RSVD) | rsvdMask[sel.select];
  assign sel.level = sel.reservedCode ? 1'b0 :
                     isRx ? rxVec[sel.select] :
                     isDev ? devVec[sel.select] :
                     txVec[sel.select];

endmodule : pin4_signal_mux

// [rtl/gpio4_output_source_mux.sv]
// pin 4 output control: apb register slave, source mux and registered pin drive
`timescale 1ns/10ps
`include "pin4_mux_defines.svh"
module gpio4_output_source_mux #(
  parameter bit LOCAL_IS_PIN0 = 1'b1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] rxRemotePins,
  input wire logic [3:0] rxLock,
  input wire logic [3:0] rxPass,
  input wire logic [3:0] rxFrameValid,
  input wire logic [3:0] rxLineValid,
  input wire logic pin0DriveValue,
  input wire logic frameSyncPulse,
  input wire logic [1:0] txFrameValid,
  input wire logic [1:0] txLineValid,
  input wire logic [1:0] txSynced,
  input wire logic [1:0] txInterrupt,
  output logic pin4Out,
  output logic pin4OutEn
);

  // ---------------------------------------------
  // register state
  // ---------------------------------------------
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic [3:0] rxEnable_ff;
  logic [3:0] nxt_rxEnable;
  logic [7:0] txRxSel_ff;
  logic [7:0] nxt_txRxSel;

  // ---------------------------------------------
  // bus slave state
  // ---------------------------------------------
  pin4_mux_pkg::bus_state_t state_ff;
  pin4_mux_pkg::bus_state_t nxt_state;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  // ---------------------------------------------
  // pin drive state
  // ---------------------------------------------
  logic pin4Out_ff;
  logic nxt_pin4Out;
  logic pin4OutEn_ff;
  logic nxt_pin4OutEn;
  logic reserved_ff;
  logic nxt_reserved;

  // ---------------------------------------------
  // control fields
  // ---------------------------------------------
  wire driveEnable = ctl_ff[`CTL_EN_BIT];
  wire driveValue = ctl_ff[`CTL_VAL_BIT];
  wire [2:0] sourceField = ctl_ff[`CTL_SRC_MSB:`CTL_SRC_LSB];
  wire [2:0] selectField = ctl_ff[`CTL_SEL_MSB:`CTL_SEL_LSB];

  // ---------------------------------------------
  // source mux
  // ---------------------------------------------
  pin_sel_if selBus ();

  assign selBus.source = sourceField;
  assign selBus.select = selectField;
  // which bit feeds the local value depends on how the pins are grouped
  assign selBus.localVal = LOCAL_IS_PIN0 ? pin0DriveValue : driveValue;
  assign selBus.rxRemote = rxRemotePins;
  assign selBus.rxLock = rxLock;
  assign selBus.rxPass = rxPass;
  assign selBus.rxFv = rxFrameValid;
  assign selBus.rxLv = rxLineValid;
  assign selBus.rxEnable = rxEnable_ff;
  assign selBus.txRxSel = txRxSel_ff;
  assign selBus.txFv = txFrameValid;
  assign selBus.txLv = txLineValid;
  assign selBus.txSync = txSynced;
  assign selBus.txIrq = txInterrupt;
  assign selBus.frameSyncIn = frameSyncPulse;

  pin4_signal_mux u_mux (
    .sel(selBus)
  );

  // ---------------------------------------------
  // address decode
  // ---------------------------------------------
  wire hitCtl = paddr == `PIN4_CTL_ADDR;
  wire hitRxEn = paddr == `RX_ENABLE_ADDR;
  wire hitTxSel = paddr == `TX_RX_SEL_ADDR;
  wire hitStatus = paddr == `PIN4_STATUS_ADDR;
  wire hitAny = hitCtl | hitRxEn | hitTxSel | hitStatus;

  // status is read-only; writes to it are accepted and dropped
  wire [31:0] statusWord = {29'h0, reserved_ff, pin4OutEn_ff, pin4Out_ff};

  wire [31:0] readWord = hitCtl ? {24'h0, ctl_ff} :
                         hitRxEn ? {28'h0, rxEnable_ff} :
                         hitTxSel ? {24'h0, txRxSel_ff} :
                         hitStatus ? statusWord :
                         32'h0;

  // ---------------------------------------------
  // transfer phases
  // ---------------------------------------------
  // one wait state keeps pready and prdata straight from flops
  wire accessStart = psel & penable & (state_ff == pin4_mux_pkg::ST_IDLE);
  wire accessDone = psel & penable & (state_ff == pin4_mux_pkg::ST_ACK);
  wire doWrite = accessDone & pwrite & hitAny;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pin4_mux_pkg::ST_IDLE: begin
        if (accessStart) begin
          nxt_state = pin4_mux_pkg::ST_ACK;
        end
      end
      pin4_mux_pkg::ST_ACK: begin
        nxt_state = pin4_mux_pkg::ST_DONE;
      end
      pin4_mux_pkg::ST_DONE: begin
        nxt_state = pin4_mux_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = pin4_mux_pkg::ST_IDLE;
      end
    endcase
  end

  assign nxt_pready = accessStart;
  assign nxt_pslverr = accessStart & ~hitAny;
  assign nxt_prdata = (accessStart & ~pwrite) ? readWord : 32'h0;

  // ---------------------------------------------
  // register writes
  // ---------------------------------------------
  assign nxt_ctl = (doWrite & hitCtl) ? pwdata[7:0] : ctl_ff;
  assign nxt_rxEnable = (doWrite & hitRxEn) ? pwdata[3:0] : rxEnable_ff;
  assign nxt_txRxSel = (doWrite & hitTxSel) ? pwdata[7:0] : txRxSel_ff;

  // ---------------------------------------------
  // pin drive
  // ---------------------------------------------
  assign nxt_pin4OutEn = driveEnable;
  // level held low while off so the pad never sees a stale value
  assign nxt_pin4Out = driveEnable & selBus.level;
  assign nxt_reserved = selBus.reservedCode;

  // ---------------------------------------------
  // flops
  // ---------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= pin4_mux_pkg::ST_IDLE;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_ff <= `PIN4_CTL_RESET;
      rxEnable_ff <= `RX_ENABLE_RESET;
      txRxSel_ff <= `TX_RX_SEL_RESET;
    end else begin
      ctl_ff <= nxt_ctl;
      rxEnable_ff <= nxt_rxEnable;
      txRxSel_ff <= nxt_txRxSel;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin4Out_ff <= 1'b0;
      pin4OutEn_ff <= 1'b0;
      reserved_ff <= 1'b0;
    end else begin
      pin4Out_ff <= nxt_pin4Out;
      pin4OutEn_ff <= nxt_pin4OutEn;
      reserved_ff <= nxt_reserved;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pin4Out = pin4Out_ff;
  assign pin4OutEn = pin4OutEn_ff;

endmodule : gpio4_output_source_mux

// [test/pin4_board_model.sv]
// board-side model of the pin 4 net
`timescale 1ns/10ps
module pin4_board_model (
  input wire logic pinOut,
  input wire logic pinOutEn,
  output logic pinLevel
);
  // released net falls to the pull-down, never keeps the last value
  assign pinLevel = pinOutEn ? pinOut : 1'b0;
endmodule : pin4_board_model

// [test/gpio4_output_source_mux_chk.sv]
// port checker for the pin 4 output mux
`timescale 1ns/10ps
`include "pin4_mux_defines.svh"
module gpio4_output_source_mux_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] rxLock,
  input wire logic pin4Out,
  input wire logic pin4OutEn
);
  // ---------------------------------------------
  // shadow of what software wrote
  // ---------------------------------------------
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic [3:0] rxEn_ff;
  logic [3:0] nxt_rxEn;
  logic wrOk;
  logic rsvd;
  logic lockSel;
  logic anyLock;
  assign wrOk = psel && penable && pready && pwrite && !pslverr;
  assign nxt_ctl = (wrOk && paddr == `PIN4_CTL_ADDR) ? pwdata[7:0] : ctl_ff;
  assign nxt_rxEn = (wrOk && paddr == `RX_ENABLE_ADDR) ? pwdata[3:0] : rxEn_ff;
  assign rsvd = ctl_ff[4:2] == 3'h5 || ctl_ff[4:3] == 2'h3 && ctl_ff[7:6] == 2'h3
    || ctl_ff[4:2] == 3'h4 && (ctl_ff[7:5] == 3'h3 || ctl_ff[7:5] > 3'h4);
  assign lockSel = rxLock[ctl_ff[3:2]];
  assign anyLock = |(rxLock & rxEn_ff);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_ff <= `PIN4_CTL_RESET;
      rxEn_ff <= `RX_ENABLE_RESET;
    end else begin
      ctl_ff <= nxt_ctl;
      rxEn_ff <= nxt_rxEn;
    end
  end
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_rdy; psel && penable |-> ##[0:2] pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  property p_off; !pin4OutEn |-> !pin4Out; endproperty
  a_off: assert property (p_off) else $error("driven while off");
  property p_en; pin4OutEn == $past(ctl_ff[0]); endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_rsvd; ctl_ff[0] && rsvd |=> !pin4Out; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved not low");
  property p_lock; ctl_ff[0] && !ctl_ff[4] && ctl_ff[7:5] == 3'h4 |=> pin4Out == $past(lockSel);
  endproperty
  a_lock: assert property (p_lock) else $error("lock wrong");
  property p_or; ctl_ff[0] && ctl_ff[7:2] == 6'h0c |=> pin4Out == $past(anyLock); endproperty
  a_or: assert property (p_or) else $error("lock or wrong");
endmodule : gpio4_output_source_mux_chk

// [test/tb_gpio4_output_source_mux.sv]
// self-checking bench for the pin 4 output mux
`timescale 1ns/10ps
`include "pin4_mux_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_gpio4_output_source_mux;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pin4Out, pin4OutEn, pinLevel, err;
  logic [15:0] rxRemotePins = 16'h3c5a;
  logic [3:0] rxLock = 4'h9, rxPass = 4'h6, rxFrameValid = 4'hc, rxLineValid = 4'h3;
  logic pin0DriveValue = 1'b0, frameSyncPulse = 1'b0;
  logic [1:0] txFrameValid = 2'h0, txLineValid = 2'h0, txSynced = 2'h0, txInterrupt = 2'h0;
  logic [3:0] rxEn = 4'hf;
  logic [7:0] txSel = 8'hff;
  int n_fail = 0, num_checks = 0, cycles = 0;
  always #2 ref_clk = ~ref_clk;
  gpio4_output_source_mux i_dut (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rxRemotePins, .rxLock, .rxPass, .rxFrameValid, .rxLineValid,
    .pin0DriveValue, .frameSyncPulse, .txFrameValid, .txLineValid, .txSynced, .txInterrupt,
    .pin4Out, .pin4OutEn);
  pin4_board_model i_board (.pinOut(pin4Out), .pinOutEn(pin4OutEn), .pinLevel);
  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // hang guard, far above the roughly 570 cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  // ---------------------------------------------
  // bus and pin helpers
  // ---------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic expOut(input logic [2:0] s, input logic [2:0] c);
    logic [3:0] m;
    m = s[0] ? txSel[7:4] : txSel[3:0];
    if (s == 3'h5) return 1'b0;
    if (!s[2]) begin
      case (c)
        3'h4: return rxLock[s[1:0]];
        3'h5: return rxPass[s[1:0]];
        3'h6: return rxFrameValid[s[1:0]];
        3'h7: return rxLineValid[s[1:0]];
        default: return rxRemotePins[{s[1:0], c[1:0]}];
      endcase
    end
    if (s == 3'h4) begin
      case (c)
        3'h0: return pin0DriveValue;
        3'h1: return |(rxLock & rxEn);
        3'h2: return rxEn != 4'h0 && &(rxPass | ~rxEn);
        3'h4: return frameSyncPulse;
        default: return 1'b0;
      endcase
    end
    case (c)
      3'h0: return m != 4'h0 && &(rxPass | ~m);
      3'h1: return |(rxPass & m);
      3'h2: return txFrameValid[s[0]];
      3'h3: return txLineValid[s[0]];
      3'h4: return txSynced[s[0]];
      3'h5: return txInterrupt[s[0]];
      default: return 1'b0;
    endcase
  endfunction : expOut
  task automatic sweep(input logic [2:0] s);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `PIN4_CTL_ADDR, {24'h0, 3'(c), s, 2'b01});
      repeat (2) @(negedge ref_clk);
      `CHK({pin4OutEn, pinLevel}, {1'b1, expOut(s, 3'(c))})
      `CHK(pin4Out, expOut(s, 3'(c)))
    end
  endtask : sweep
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_regs();
    apb(1'b0, `PIN4_CTL_ADDR, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, `PIN4_CTL_ADDR, 32'hffff_ffa6);
    apb(1'b0, `PIN4_CTL_ADDR, 32'h0);
    `CHK(rd, 32'ha6)
    repeat (2) @(negedge ref_clk);
    `CHK({pin4OutEn, pin4Out, pinLevel}, 3'h0)
    apb(1'b1, 8'h40, 32'h1);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask : t_regs
  task automatic t_rx();
    for (int k = 0; k < 2; k++) begin
      for (int s = 0; s < 4; s++) sweep(3'(s));
      @(posedge ref_clk);
      rxRemotePins <= ~rxRemotePins;
      rxLock <= ~rxLock;
      rxPass <= ~rxPass;
      rxFrameValid <= ~rxFrameValid;
      rxLineValid <= ~rxLineValid;
    end
  endtask : t_rx
  task automatic t_dev();
    apb(1'b1, `RX_ENABLE_ADDR, 32'h5);
    rxEn = 4'h5;
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      pin0DriveValue <= !k;
      frameSyncPulse <= !k;
      rxLock <= k ? 4'h1 : 4'ha;
      rxPass <= k ? 4'h4 : 4'h5;
      sweep(3'h4);
    end
  endtask : t_dev
  task automatic t_tx();
    apb(1'b1, `TX_RX_SEL_ADDR, 32'h6c);
    txSel = 8'h6c;
    @(posedge ref_clk);
    rxPass <= 4'hc;
    txFrameValid <= 2'b01;
    txLineValid <= 2'b10;
    txSynced <= 2'b01;
    txInterrupt <= 2'b10;
    sweep(3'h6);
    sweep(3'h7);
    sweep(3'h5);
    apb(1'b0, `PIN4_STATUS_ADDR, 32'h0);
    `CHK({err, rd}, {1'b0, 32'h6})
  endtask : t_tx
  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_rx();
    t_dev();
    t_tx();
    stop_test();
  end
endmodule : tb_gpio4_output_source_mux
bind gpio4_output_source_mux gpio4_output_source_mux_chk i_chk (.ref_clk, .arst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxLock, .pin4Out, .pin4OutEn);
